// file: bench/pllcfg_chk.sv
// assertion checker on the pll clock path config ports
`include "pllcfg_regs.vh"
module pllcfg_chk (
  input wire        clk_in,
  input wire        reset_in,
  input wire        hsel_in,
  input wire [31:0] haddr_in,
  input wire [1:0]  htrans_in,
  input wire        hwrite_in,
  input wire [31:0] hwdata_in,
  input wire        hready_in,
  input wire        ref_div_edge_in,
  input wire        fb_div_edge_in,
  input wire        hreadyout_out,
  input wire        hresp_out,
  input wire [1:0]  pll_power_out,
  input wire [1:0]  pump_mode_out,
  input wire [2:0]  pump_current_out,
  input wire        pfd_negative_out,
  input wire [1:0]  antibacklash_out,
  input wire [2:0]  vco_div_ratio_out,
  input wire        src_vco_out,
  input wire        div_bypass_out,
  input wire        vco_enable_out,
  input wire        prescaler_ext_out,
  input wire        pump_up_out,
  input wire        pump_down_out
);
  default clocking @(posedge clk_in); endclocking
  default disable iff (reset_in);
  reg         cw_r;
  reg  [3:0]  cm_r;
  wire [14:0] cfg = {pll_power_out, pump_mode_out, pump_current_out, pfd_negative_out,
                     antibacklash_out, vco_div_ratio_out, src_vco_out, div_bypass_out};
  wire        pw0 = pll_power_out == `PLLCFG_PWR_NORMAL;
  wire        calm = !fb_div_edge_in && pw0 && pump_mode_out == `PLLCFG_PUMP_NORMAL;
  // commit history: settings may only move a few cycles after a commit write
  always @(posedge clk_in) begin
    cw_r <= hsel_in && hready_in && htrans_in[1] && hwrite_in
            && haddr_in[11:2] == `PLLCFG_IDX_COMMIT;
    cm_r <= {cm_r[2:0], cw_r && hwdata_in[0]};
  end
  sequence s_ref_only;
    (calm && !pump_up_out && !pump_down_out)[*3] ##1 ($rose(ref_div_edge_in) && calm)
      ##1 (calm && $stable(pfd_negative_out))[*3];
  endsequence
  AST_BUS_OKAY:
    assert property (!hresp_out && (hreadyout_out || $past(hreadyout_out)))
      else $error("bus error or long wait seen");
  AST_DEFAULTS:
    assert property ($fell(reset_in) |-> pll_power_out == 2'h1 && vco_div_ratio_out == 3'h2
      && !src_vco_out && !div_bypass_out) else $error("defaults missing after reset");
  AST_VCO_OFF:
    assert property (vco_enable_out == src_vco_out) else $error("vco power not tied to source");
  AST_PRESCALER:
    assert property (prescaler_ext_out != src_vco_out) else $error("prescaler feed wrong");
  AST_COMMIT_ONLY:
    assert property ($changed(cfg) |-> |cm_r) else $error("settings moved without commit");
  AST_PWR_DOWN:
    assert property (!pw0 [*3] |-> !pump_up_out && !pump_down_out)
      else $error("pump active while pll powered down");
  AST_FORCE_UP:
    assert property ((pw0 && pump_mode_out == `PLLCFG_PUMP_UP)[*3] |-> pump_up_out
      && !pump_down_out) else $error("forced up mode wrong");
  AST_FORCE_DN:
    assert property ((pw0 && pump_mode_out == `PLLCFG_PUMP_DOWN)[*3] |-> pump_down_out
      && !pump_up_out) else $error("forced down mode wrong");
  AST_PFD_REF:
    assert property (s_ref_only |-> (pfd_negative_out ? pump_down_out : pump_up_out))
      else $error("reference edge did not drive pump");
endmodule
bind pllcfg_top pllcfg_chk i_chk (.*);

// file: bench/tb.sv
// self-checking bench for the pll clock path config block
`include "pllcfg_regs.vh"
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_in, reset_in, hsel_in, hwrite_in, hready_in, ref_div_edge_in;
  logic        fb_div_edge_in, hreadyout_out, hresp_out, pfd_negative_out, src_vco_out;
  logic        div_bypass_out, vco_enable_out, prescaler_ext_out, vco_cal_start_out;
  logic        pump_up_out, pump_down_out;
  logic [31:0] haddr_in, hwdata_in, hrdata_out, d, e, w;
  logic [1:0]  htrans_in, pll_power_out, pump_mode_out, antibacklash_out;
  logic [2:0]  hsize_in, pump_current_out, vco_div_ratio_out;
  logic [9:0]  ix [4] = '{10'h010, 10'h017, 10'h1e0, 10'h1e1};
  logic [7:0]  m [4] = '{8'hff, 8'h03, 8'h07, 8'h03};
  logic [7:0]  r [4], pv [4];
  int          fails = 0, checks = 0, cyc = 0;
  assign hready_in = hreadyout_out;
  pllcfg_top i_dut (.*);
  initial begin
    clk_in = 0;
    forever #5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      fails = fails + 1;
      print_verdict();
    end
  end
  task automatic print_verdict();
    if (fails == 0 && checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, x);
    checks++;
    if (g !== x) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, x);
    end
  endtask
  // waits are bounded only by the global cycle ceiling
  task automatic bus(input logic wr, input logic [9:0] i, input logic [31:0] wd);
    hsel_in <= 1;
    haddr_in <= {20'h0, i, 2'h0};
    htrans_in <= 2'h2;
    hwrite_in <= wr;
    hsize_in <= 3'h2;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    htrans_in <= 2'h0;
    hwdata_in <= wd;
    do @(posedge clk_in); while (hreadyout_out !== 1'b1);
    d = hrdata_out;
  endtask
  function automatic logic [2:0] ratio(input logic [2:0] c);
    return c == 3'h5 ? 3'h1 : c > 3'h4 ? 3'h6 : c + 3'h2;
  endfunction
  task automatic outs(input logic [7:0] p, a, v, s, c);
    logic up, dn;
    up = p[3:0] == 4'h4;
    dn = p[3:0] == 4'h8;
    chk({pll_power_out, pump_mode_out, pump_current_out, pfd_negative_out, antibacklash_out,
         vco_div_ratio_out, src_vco_out, div_bypass_out, vco_enable_out, prescaler_ext_out,
         pump_up_out, pump_down_out, vco_cal_start_out}, {p[1:0], p[3:2], p[6:4], p[7],
         a[1:0], ratio(v[2:0]), s[1:0], s[1], !s[1], up, dn, c[0] & !p[0] & !p[1] & s[1]});
    bus(0, `PLLCFG_IDX_ACTIVE_STAT, 0);
    chk(d, {s[1], !s[1], s[1], s[0], up, dn, p[1:0]});
  endtask
  task automatic commit();
    bus(1, `PLLCFG_IDX_COMMIT, 1);
    repeat (3) @(posedge clk_in);
  endtask
  task automatic rst();
    reset_in <= 1;
    repeat (6) @(posedge clk_in);
    reset_in <= 0;
    @(posedge clk_in);
    outs(8'h01, 0, 0, 0, 0);
    for (int k = 0; k < 4; k++) begin
      bus(0, ix[k], 0);
      chk(d, k == 0);
    end
  endtask
  initial begin
    {hsel_in, hwrite_in, ref_div_edge_in, fb_div_edge_in, htrans_in, hsize_in} = 0;
    {haddr_in, hwdata_in} = 0;
    reset_in = 1;
    d = $urandom(98801);
    rst();
    pv = '{8'h01, 0, 0, 0};
    for (int i = 0; i < 8; i++) begin
      for (int k = 0; k < 4; k++) begin
        w = $urandom;
        if (k == 0 && i < 2) w[3:0] = i ? 4'h8 : 4'h4;
        if (k == 2) w[2:0] = i;
        r[k] = w[7:0] & m[k];
        bus(1, ix[k], w);
      end
      for (int k = 0; k < 4; k++) begin
        bus(0, ix[k], 0);
        chk(d, r[k]);
      end
      outs(pv[0], pv[1], pv[2], pv[3], 0);
      commit();
      outs(r[0], r[1], r[2], r[3], 0);
      pv = r;
    end
    bus(1, 10'h100, $urandom);
    bus(0, 10'h100, 0);
    chk(d, 0);
    rst();
    for (int c = 1; c >= 0; c--) begin
      bus(1, `PLLCFG_IDX_PWR_PUMP, 0);
      bus(1, `PLLCFG_IDX_SRC_ROUTE, 2);
      bus(1, `PLLCFG_IDX_VCO_CAL, c);
      commit();
      outs(0, 0, 0, 2, c);
    end
    for (int n = 0; n < 2; n++) begin
      bus(1, `PLLCFG_IDX_PWR_PUMP, {n[0], 7'h0c});
      commit();
      repeat (3) @(posedge clk_in);
      for (int j = 0; j < 4; j++) begin
        if (j == 0 || j == 3) ref_div_edge_in <= 1;
        else fb_div_edge_in <= 1;
        @(posedge clk_in);
        ref_div_edge_in <= 0;
        fb_div_edge_in <= 0;
        repeat (3) @(posedge clk_in);
        e = j == 0 ? 2'h2 : j == 2 ? 2'h1 : 2'h0;
        if (n == 1) e = {30'h0, e[0], e[1]};
        chk({pump_up_out, pump_down_out}, e);
      end
    end
    print_verdict();
  end
endmodule

// file: logic/pllcfg_regs.vh
// register offsets, field positions, encodings and reset values for the pll clock path config
`ifndef PLLCFG_REGS_VH
`define PLLCFG_REGS_VH
// register indices (printed offsets); byte address is four times the index
`define PLLCFG_IDX_PWR_PUMP      10'h010
`define PLLCFG_IDX_ANTIBACKLASH  10'h017
`define PLLCFG_IDX_VCO_CAL       10'h018
`define PLLCFG_IDX_VCO_DIV       10'h1e0
`define PLLCFG_IDX_SRC_ROUTE     10'h1e1
`define PLLCFG_IDX_COMMIT        10'h232
`define PLLCFG_IDX_ACTIVE_STAT   10'h3f0
// fields of the pll power and pump control register
`define PLLCFG_PWR_LSB           0
`define PLLCFG_PUMP_MODE_LSB     2
`define PLLCFG_CP_CUR_LSB        4
`define PLLCFG_PFD_POL_BIT       7
// field encodings
`define PLLCFG_PWR_NORMAL        2'h0
`define PLLCFG_PWR_ASYNC_DOWN    2'h1
`define PLLCFG_PUMP_HIZ          2'h0
`define PLLCFG_PUMP_UP           2'h1
`define PLLCFG_PUMP_DOWN         2'h2
`define PLLCFG_PUMP_NORMAL       2'h3
// reset values
`define PLLCFG_RST_PWR_PUMP      8'h01
`define PLLCFG_RST_ANTIBACKLASH  8'h00
`define PLLCFG_RST_VCO_CAL       8'h00
`define PLLCFG_RST_VCO_DIV       8'h00
`define PLLCFG_RST_SRC_ROUTE     8'h00
// source routing bits
`define PLLCFG_ROUTE_BYPASS_BIT  0
`define PLLCFG_ROUTE_SRC_VCO_BIT 1
// commit strobe bit and calibration bit
`define PLLCFG_COMMIT_BIT        0
`define PLLCFG_CAL_BIT           0
// vco divider select: code 0 gives 2, codes 1..4 give 3..6, code 5 gives 1
`define PLLCFG_VCO_DIV_MAX_CODE  3'h5
`endif

// file: logic/pllcfg_top.v
// pll power, charge pump, pfd and distribution source routing configuration with ahb-lite slave
//
// Operation
// [R1] after power-up pll sits in async power-down; external clock goes through vco divider
// [R2] routing and pll power defaults reload at power-up and on every reset
// [R3] vco divider ratios 1 to 6; select code 000b means divide by two
// [R4] source bit clear picks external clock; bypass bit clear routes through divider
// [R5] software writes 00b to pll power field for normal pll operation
// [R6] with external clock selected the internal vco stays unused and off
// [R7] with external vco the oscillator input feeds the feedback prescaler directly
// [R8] pfd polarity bit: 0 positive, 1 negative tuning slope
// [R9] pfd compares reference and feedback divider outputs, drives pump up or down
// [R10] two-bit field sets antibacklash pulse width of the pfd delay element
// [R11] two-bit pump mode: high impedance, normal, forced up, forced down
// [R12] charge pump current has eight steps from 0.6 to 4.8 milliamp
// [R13] software calibrates vco at first setup and when nominal frequency changes
// [R14] software sets calibration bit then commits; clears and commits before recalibrating
// [R15] routing and pll control take effect only on the commit strobe
`include "pllcfg_regs.vh"
module pllcfg_top (
  input  wire        clk_in,
  input  wire        reset_in,
  input  wire        hsel_in,
  input  wire [31:0] haddr_in,
  input  wire [1:0]  htrans_in,
  input  wire        hwrite_in,
  input  wire [2:0]  hsize_in,
  input  wire [31:0] hwdata_in,
  input  wire        hready_in,
  input  wire        ref_div_edge_in,
  input  wire        fb_div_edge_in,
  output reg  [31:0] hrdata_out,
  output wire        hreadyout_out,
  output wire        hresp_out,
  output reg  [1:0]  pll_power_out,
  output reg  [1:0]  pump_mode_out,
  output reg  [2:0]  pump_current_out,
  output reg         pfd_negative_out,
  output reg  [1:0]  antibacklash_out,
  output reg  [2:0]  vco_div_ratio_out,
  output reg         src_vco_out,
  output reg         div_bypass_out,
  output reg         vco_enable_out,
  output reg         prescaler_ext_out,
  output reg         vco_cal_start_out,
  output reg         pump_up_out,
  output reg         pump_down_out
);

  // staged (software-visible) registers
  reg  [7:0] pwr_pump_r;
  reg  [7:0] antibacklash_r;
  reg  [7:0] vco_cal_r;
  reg  [7:0] vco_div_r;
  reg  [7:0] src_route_r;
  // active copies loaded by the commit strobe
  reg  [7:0] act_pwr_pump_r;
  reg  [7:0] act_antibacklash_r;
  reg  [7:0] act_vco_div_r;
  reg  [7:0] act_src_route_r;
  reg        act_cal_r;
  // ahb address phase capture
  reg        wr_pend_r;
  reg        rd_pend_r;
  reg  [9:0] idx_r;
  reg  [7:0] rd_nxt;
  reg  [2:0] ratio_nxt;
  reg        pfd_up_r;
  reg        pfd_down_r;
  reg        ref_d_r;
  reg        fb_d_r;

  wire       addr_phase;
  wire [9:0] addr_idx;
  wire       commit;
  wire       ref_rise;
  wire       fb_rise;
  wire       pll_on;

  assign addr_phase    = hsel_in & hready_in & htrans_in[1];
  assign addr_idx      = haddr_in[11:2];
  // one wait state on reads so the registered read data stands when hready is sampled
  assign hreadyout_out = ~rd_pend_r;
  assign hresp_out     = 1'b0;
  // commit is a write of 1 to the strobe bit; the register itself holds nothing
  assign commit        = wr_pend_r & (idx_r == `PLLCFG_IDX_COMMIT) &
                         hwdata_in[`PLLCFG_COMMIT_BIT];

  always @(posedge clk_in) begin
    if (reset_in) begin
      wr_pend_r <= 1'b0;
      rd_pend_r <= 1'b0;
      idx_r     <= 10'h000;
    end else begin
      wr_pend_r <= addr_phase & hwrite_in;
      rd_pend_r <= addr_phase & ~hwrite_in;
      if (addr_phase) begin
        idx_r <= addr_idx;
      end
    end
  end

  // staged register writes; reset reloads the defaults
  always @(posedge clk_in) begin
    if (reset_in) begin
      pwr_pump_r     <= `PLLCFG_RST_PWR_PUMP; // [R1] [R2]
      antibacklash_r <= `PLLCFG_RST_ANTIBACKLASH;
      vco_cal_r      <= `PLLCFG_RST_VCO_CAL;
      vco_div_r      <= `PLLCFG_RST_VCO_DIV; // [R3]
      src_route_r    <= `PLLCFG_RST_SRC_ROUTE; // [R2] [R4]
    end else if (wr_pend_r) begin
      case (idx_r)
        `PLLCFG_IDX_PWR_PUMP:     pwr_pump_r     <= hwdata_in[7:0];
        `PLLCFG_IDX_ANTIBACKLASH: antibacklash_r <= {6'h00, hwdata_in[1:0]}; // [R10]
        `PLLCFG_IDX_VCO_CAL:      vco_cal_r      <= {7'h00, hwdata_in[0]};
        `PLLCFG_IDX_VCO_DIV:      vco_div_r      <= {5'h00, hwdata_in[2:0]};
        `PLLCFG_IDX_SRC_ROUTE:    src_route_r    <= {6'h00, hwdata_in[1:0]};
        default: ;
      endcase
    end
  end

  // active copies change only on commit so multi-field changes land together
  always @(posedge clk_in) begin
    if (reset_in) begin
      act_pwr_pump_r     <= `PLLCFG_RST_PWR_PUMP; // [R1] [R2]
      act_antibacklash_r <= `PLLCFG_RST_ANTIBACKLASH;
      act_vco_div_r      <= `PLLCFG_RST_VCO_DIV;
      act_src_route_r    <= `PLLCFG_RST_SRC_ROUTE;
      act_cal_r          <= 1'b0;
    end else if (commit) begin
      act_pwr_pump_r     <= pwr_pump_r; // [R15]
      act_antibacklash_r <= antibacklash_r;
      act_vco_div_r      <= vco_div_r;
      act_src_route_r    <= src_route_r;
      act_cal_r          <= vco_cal_r[`PLLCFG_CAL_BIT];
    end
  end

  // read mux; unmapped indices read zero
  always @* begin
    rd_nxt = 8'h00;
    case (idx_r)
      `PLLCFG_IDX_PWR_PUMP:     rd_nxt = pwr_pump_r;
      `PLLCFG_IDX_ANTIBACKLASH: rd_nxt = antibacklash_r;
      `PLLCFG_IDX_VCO_CAL:      rd_nxt = vco_cal_r;
      `PLLCFG_IDX_VCO_DIV:      rd_nxt = vco_div_r;
      `PLLCFG_IDX_SRC_ROUTE:    rd_nxt = src_route_r;
      `PLLCFG_IDX_ACTIVE_STAT:  rd_nxt = {vco_enable_out, prescaler_ext_out, src_vco_out,
                                          div_bypass_out, pump_up_out, pump_down_out,
                                          act_pwr_pump_r[1:0]};
      default:                  rd_nxt = 8'h00;
    endcase
  end

  // read data stands in the data phase, two cycles after the address phase
  always @(posedge clk_in) begin
    if (reset_in) begin
      hrdata_out <= 32'h00000000;
    end else if (rd_pend_r) begin
      hrdata_out <= {24'h000000, rd_nxt};
    end else if (addr_phase & ~hwrite_in) begin
      hrdata_out <= 32'h00000000;
    end
  end

  // divider select code to ratio; codes above the top one hold at six
  always @* begin
    case (act_vco_div_r[2:0])
      3'h0:    ratio_nxt = 3'h2; // [R3]
      3'h1:    ratio_nxt = 3'h3;
      3'h2:    ratio_nxt = 3'h4;
      3'h3:    ratio_nxt = 3'h5;
      3'h4:    ratio_nxt = 3'h6;
      3'h5:    ratio_nxt = 3'h1;
      default: ratio_nxt = 3'h6;
    endcase
  end

  assign pll_on = (act_pwr_pump_r[1:0] == `PLLCFG_PWR_NORMAL);

  // decoded configuration outputs
  always @(posedge clk_in) begin
    if (reset_in) begin
      pll_power_out     <= `PLLCFG_PWR_ASYNC_DOWN; // [R1]
      pump_mode_out     <= `PLLCFG_PUMP_HIZ;
      pump_current_out  <= 3'h0;
      pfd_negative_out  <= 1'b0;
      antibacklash_out  <= 2'h0;
      vco_div_ratio_out <= 3'h2;
      src_vco_out       <= 1'b0;
      div_bypass_out    <= 1'b0;
      vco_enable_out    <= 1'b0;
      prescaler_ext_out <= 1'b1;
      vco_cal_start_out <= 1'b0;
    end else begin
      pll_power_out     <= act_pwr_pump_r[1:0]; // [R5]
      pump_mode_out     <= act_pwr_pump_r[3:2]; // [R11]
      pump_current_out  <= act_pwr_pump_r[6:4]; // [R12]
      pfd_negative_out  <= act_pwr_pump_r[`PLLCFG_PFD_POL_BIT]; // [R8]
      antibacklash_out  <= act_antibacklash_r[1:0]; // [R10]
      vco_div_ratio_out <= ratio_nxt; // [R3]
      src_vco_out       <= act_src_route_r[`PLLCFG_ROUTE_SRC_VCO_BIT]; // [R4]
      div_bypass_out    <= act_src_route_r[`PLLCFG_ROUTE_BYPASS_BIT]; // [R4]
      // internal vco powers only when it is the chosen source
      vco_enable_out    <= act_src_route_r[`PLLCFG_ROUTE_SRC_VCO_BIT]; // [R6]
      prescaler_ext_out <= ~act_src_route_r[`PLLCFG_ROUTE_SRC_VCO_BIT]; // [R7]
      // calibration only starts if the vco is the source and the loop is powered
      vco_cal_start_out <= act_cal_r & pll_on &
                           act_src_route_r[`PLLCFG_ROUTE_SRC_VCO_BIT]; // [R14]
    end
  end

  // rising edge detection on the divider outputs; inputs are from logic on this clock
  wire ref_now = ref_div_edge_in;
  wire fb_now  = fb_div_edge_in;
  assign ref_rise = ref_now & ~ref_d_r;
  assign fb_rise  = fb_now & ~fb_d_r;

  // three-state pfd: an edge on one side raises its flag, both raised clear together
  always @(posedge clk_in) begin
    if (reset_in) begin
      ref_d_r    <= 1'b0;
      fb_d_r     <= 1'b0;
      pfd_up_r   <= 1'b0;
      pfd_down_r <= 1'b0;
    end else begin
      ref_d_r <= ref_now;
      fb_d_r  <= fb_now;
      if (!pll_on) begin
        pfd_up_r   <= 1'b0;
        pfd_down_r <= 1'b0;
      end else if ((pfd_up_r | ref_rise) & (pfd_down_r | fb_rise)) begin
        pfd_up_r   <= 1'b0; // [R9]
        pfd_down_r <= 1'b0;
      end else begin
        pfd_up_r   <= pfd_up_r | ref_rise; // [R9]
        pfd_down_r <= pfd_down_r | fb_rise;
      end
    end
  end

  // pump drive after mode and polarity; in normal mode negative polarity swaps the directions
  always @(posedge clk_in) begin
    if (reset_in) begin
      pump_up_out   <= 1'b0;
      pump_down_out <= 1'b0;
    end else if (!pll_on) begin
      pump_up_out   <= 1'b0;
      pump_down_out <= 1'b0;
    end else begin
      case (act_pwr_pump_r[3:2]) // [R11]
        `PLLCFG_PUMP_UP: begin
          pump_up_out   <= 1'b1;
          pump_down_out <= 1'b0;
        end
        `PLLCFG_PUMP_DOWN: begin
          pump_up_out   <= 1'b0;
          pump_down_out <= 1'b1;
        end
        `PLLCFG_PUMP_NORMAL: begin
          pump_up_out   <= act_pwr_pump_r[7] ? pfd_down_r : pfd_up_r; // [R8] [R9]
          pump_down_out <= act_pwr_pump_r[7] ? pfd_up_r : pfd_down_r;
        end
        default: begin
          pump_up_out   <= 1'b0;
          pump_down_out <= 1'b0;
        end
      endcase
    end
  end

endmodule
